/* design/wdt_lf_tick.sv */
// low-frequency oscillator tick generator for the watchdog
`timescale 1ns/1ps
`include "wdt_defs.svh"
module wdt_lf_tick
  import wdt_pkg::*;
(
  input  wire logic clk,      // system clock
  input  wire logic rst,      // synchronous reset, active high
  input  wire logic enable,   // oscillator running
  input  wire logic restart,  // restart the phase
  output logic      lf_tick   // one-cycle tick at oscillator rate
);

  localparam wdt_div_t DIV_LAST = wdt_div_t'(`WDT_LF_DIV_CYC - 1);

  wdt_div_t div_cnt;

  // ==========================================================
  // divider
  // counts one oscillator period, held at zero while stopped
  always_ff @(posedge clk) begin
    if (rst || !enable || restart) begin
      div_cnt <= '0;
    end else if (div_cnt == DIV_LAST) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + wdt_div_t'(1);
    end
  end

  // tick on the last count of each period
  assign lf_tick = enable && !restart && (div_cnt == DIV_LAST); // [RULE1]

  // ==========================================================
  // checks
  property p_tick_needs_osc;
    @(posedge clk) disable iff (rst)
      lf_tick |-> enable && $past(enable) && div_cnt == DIV_LAST;
  endproperty
  a_tick_needs_osc: assert property (p_tick_needs_osc) // [RULE1]
    else $error("oscillator tick while oscillator stopped");

endmodule

/* design/wdt_top.sv */
// watchdog timer with base stage, postscaler and timeout tap select
`timescale 1ns/1ps
`include "wdt_defs.svh"
// Behaviour
// (RULE1) counter runs from the low-frequency oscillator, enabled together with watchdog
// (RULE2) base stage yields a 4 ms period before postscaling
// (RULE3) base period drives a 16-bit postscaler multiplying the timeout
// (RULE4) tap select from second high configuration word picks a postscaler output
// (RULE5) timeout spans 4 ms up to 131.072 s at the largest tap
// (RULE6) clear or sleep instruction zeroes base counter and postscaler
// (RULE7) change of oscillator frequency select zeroes base counter and postscaler
// (RULE8) clock failure zeroes base counter and postscaler
// (RULE9) expiry of the chosen tap without a clear asserts a device reset
module wdt_top
  import wdt_pkg::*;
(
  input  wire logic      clk,                      // system clock, 20 MHz
  input  wire logic      rst,                      // synchronous reset, active high
  input  wire logic      watchdog_enable,          // watchdog on
  input  wire wdt_sel_t  config_word_two_high_sel, // postscaler tap select
  input  wire logic      watchdog_clear_instr,     // clear instruction executed
  input  wire logic      sleep_instr,              // sleep instruction executed
  input  wire wdt_freq_t internal_osc_freq_select, // oscillator frequency select
  input  wire logic      clock_fail,               // clock failure detected
  output logic           low_freq_osc_en,          // oscillator enable
  output logic           watchdog_timeout          // one-cycle device reset request
);

  localparam wdt_base_t BASE_LAST = wdt_base_t'(`WDT_BASE_TICKS - 1);
  localparam wdt_gap_t  BASE_GAP  = wdt_gap_t'(`WDT_BASE_CYC - 1);

  // ==========================================================
  // tap decode
  // low-order postscaler bits that must all be set to expire
  function automatic wdt_ps_t tap_mask(input wdt_sel_t sel);
    logic [`WDT_PS_WIDTH:0] full;
    full     = ({{`WDT_PS_WIDTH{1'b0}}, 1'b1} << sel) - 17'h00001;
    tap_mask = full[`WDT_PS_WIDTH-1:0]; // [RULE5]
  endfunction

  wdt_base_t base_cnt;
  wdt_ps_t   ps_cnt;
  wdt_freq_t freq_prev;
  logic      lf_tick;
  logic      freq_change;
  logic      clr_all;
  logic      base_tick;
  logic      expire;

  // ==========================================================
  // oscillator
  // the watchdog enable also starts its clock source
  assign low_freq_osc_en = watchdog_enable; // [RULE1]

  wdt_lf_tick u_lf_tick (
    .clk     (clk),
    .rst     (rst),
    .enable  (low_freq_osc_en),
    .restart (clr_all),
    .lf_tick (lf_tick)
  );

  // ==========================================================
  // clear sources
  // remember the frequency select to see a write that changes it
  always_ff @(posedge clk) begin
    if (rst) begin
      freq_prev <= `WDT_FREQ_SEL_RST;
    end else begin
      freq_prev <= internal_osc_freq_select;
    end
  end

  assign freq_change = (internal_osc_freq_select != freq_prev);         // [RULE7]
  // any clear source restarts the whole chain; a clear beats an expiry
  assign clr_all = watchdog_clear_instr || sleep_instr                  // [RULE6]
                   || freq_change || clock_fail || !watchdog_enable;    // [RULE8]

  // ==========================================================
  // base stage
  // 125 oscillator ticks make one 4 ms base period
  always_ff @(posedge clk) begin
    if (rst || clr_all) begin
      base_cnt <= '0;                                                   // [RULE6]
    end else if (lf_tick) begin
      if (base_cnt == BASE_LAST) begin
        base_cnt <= '0;
      end else begin
        base_cnt <= base_cnt + wdt_base_t'(1);
      end
    end
  end

  assign base_tick = lf_tick && (base_cnt == BASE_LAST);                // [RULE2]

  // ==========================================================
  // postscaler
  // expiry when every bit below the chosen tap is set at a base tick
  assign expire = base_tick
                  && ((ps_cnt & tap_mask(config_word_two_high_sel))
                      == tap_mask(config_word_two_high_sel));           // [RULE4]

  always_ff @(posedge clk) begin
    if (rst || clr_all) begin
      ps_cnt <= '0;                                                     // [RULE6]
    end else if (expire) begin
      ps_cnt <= '0;                                                     // [RULE9]
    end else if (base_tick) begin
      ps_cnt <= ps_cnt + wdt_ps_t'(1);                                  // [RULE3]
    end
  end

  // ==========================================================
  // timeout
  // registered pulse, one cycle after the expiring base tick
  always_ff @(posedge clk) begin
    if (rst) begin
      watchdog_timeout <= 1'b0;
    end else begin
      watchdog_timeout <= expire;                                       // [RULE9]
    end
  end

  // ==========================================================
  // checks
  // cycles since the chain last restarted or ticked
  wdt_gap_t gap_cnt;

  always_ff @(posedge clk) begin
    if (rst || clr_all || base_tick) begin
      gap_cnt <= '0;
    end else if (gap_cnt != '1) begin
      gap_cnt <= gap_cnt + wdt_gap_t'(1);
    end
  end

  property p_base_period;
    @(posedge clk) disable iff (rst)
      base_tick |-> gap_cnt == BASE_GAP;
  endproperty
  a_base_period: assert property (p_base_period) // [RULE2]
    else $error("base tick not 4 ms after previous restart");

  property p_osc_follows_en;
    @(posedge clk) disable iff (rst)
      !watchdog_enable |-> !lf_tick ##1 (base_cnt == '0 && ps_cnt == '0);
  endproperty
  a_osc_follows_en: assert property (p_osc_follows_en) // [RULE1]
    else $error("watchdog counts while disabled");

  property p_ps_step;
    @(posedge clk) disable iff (rst)
      base_tick && !expire && !clr_all |=> ps_cnt == $past(ps_cnt) + wdt_ps_t'(1);
  endproperty
  a_ps_step: assert property (p_ps_step) // [RULE3]
    else $error("postscaler did not advance on base tick");

  property p_ps_hold;
    @(posedge clk) disable iff (rst)
      !base_tick && !clr_all |=> $stable(ps_cnt);
  endproperty
  a_ps_hold: assert property (p_ps_hold) // [RULE3]
    else $error("postscaler moved without base tick");

  property p_tap_match;
    @(posedge clk) disable iff (rst)
      watchdog_timeout |-> $past(base_tick)
        && (($past(ps_cnt) & tap_mask($past(config_word_two_high_sel)))
            == tap_mask($past(config_word_two_high_sel)));
  endproperty
  a_tap_match: assert property (p_tap_match) // [RULE4]
    else $error("timeout not at the selected tap");

  property p_shortest;
    @(posedge clk) disable iff (rst)
      base_tick && !clr_all && config_word_two_high_sel == 4'h0 |=> watchdog_timeout;
  endproperty
  a_shortest: assert property (p_shortest) // [RULE5]
    else $error("shortest tap did not expire at first base tick");

  property p_instr_clear;
    @(posedge clk) disable iff (rst)
      (watchdog_clear_instr || sleep_instr)
        |=> base_cnt == '0 && ps_cnt == '0 && !watchdog_timeout;
  endproperty
  a_instr_clear: assert property (p_instr_clear) // [RULE6]
    else $error("clear or sleep did not zero the counts");

  property p_freq_clear;
    @(posedge clk) disable iff (rst)
      $changed(internal_osc_freq_select) |=> base_cnt == '0 && ps_cnt == '0;
  endproperty
  a_freq_clear: assert property (p_freq_clear) // [RULE7]
    else $error("frequency select change did not zero the counts");

  property p_fail_clear;
    @(posedge clk) disable iff (rst)
      clock_fail |=> base_cnt == '0 && ps_cnt == '0 && !watchdog_timeout;
  endproperty
  a_fail_clear: assert property (p_fail_clear) // [RULE8]
    else $error("clock failure did not zero the counts");

  property p_timeout_restart;
    @(posedge clk) disable iff (rst)
      watchdog_timeout |-> ps_cnt == '0 && !$past(clr_all) ##1 !watchdog_timeout;
  endproperty
  a_timeout_restart: assert property (p_timeout_restart) // [RULE9]
    else $error("timeout not a single pulse from a clean count");

  // the top postscaler bit is never reached, the longest tap restarts first
  property p_ps_ceiling;
    @(posedge clk) disable iff (rst)
      !ps_cnt[`WDT_PS_WIDTH-1];
  endproperty
  a_ps_ceiling: assert property (p_ps_ceiling) // [RULE5]
    else $error("postscaler ran past the longest tap");

  // main scenarios
  c_timeout: cover property (@(posedge clk) disable iff (rst) watchdog_timeout);
  c_long_tap: cover property (@(posedge clk) disable iff (rst)
    base_tick && config_word_two_high_sel == 4'hF && ps_cnt == 16'h7FFF);
  c_clear_mid: cover property (@(posedge clk) disable iff (rst)
    watchdog_clear_instr && ps_cnt != '0);
  c_freq_change: cover property (@(posedge clk) disable iff (rst)
    freq_change && base_cnt != '0);
  c_sleep_clear: cover property (@(posedge clk) disable iff (rst)
    sleep_instr && base_cnt != '0);

endmodule

/* pkg/wdt_defs.svh */
// watchdog timer constants: timing counts, widths and reset values
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// ==========================================================
// clocking
`define WDT_CLK_PERIOD_NS  50
`define WDT_LF_PERIOD_NS   32000
`define WDT_LF_DIV_CYC     (`WDT_LF_PERIOD_NS / `WDT_CLK_PERIOD_NS)

// ==========================================================
// base stage and postscaler
`define WDT_BASE_PERIOD_NS 4000000
`define WDT_BASE_TICKS     (`WDT_BASE_PERIOD_NS / `WDT_LF_PERIOD_NS)
`define WDT_BASE_CYC       (`WDT_BASE_TICKS * `WDT_LF_DIV_CYC)
`define WDT_DIV_WIDTH      10
`define WDT_BASE_WIDTH     7
`define WDT_PS_WIDTH       16
`define WDT_SEL_WIDTH      4
`define WDT_GAP_WIDTH      17

// ==========================================================
// reset values
`define WDT_FREQ_SEL_RST   3'h3

`endif

/* pkg/wdt_pkg.sv */
// watchdog timer types
package wdt_pkg;
  `include "wdt_defs.svh"

  typedef logic [`WDT_DIV_WIDTH-1:0]  wdt_div_t;
  typedef logic [`WDT_BASE_WIDTH-1:0] wdt_base_t;
  typedef logic [`WDT_PS_WIDTH-1:0]   wdt_ps_t;
  typedef logic [`WDT_SEL_WIDTH-1:0]  wdt_sel_t;
  typedef logic [2:0]                 wdt_freq_t;
  typedef logic [`WDT_GAP_WIDTH-1:0]  wdt_gap_t;
endpackage

/* testbench/watchdog_timer_postscaled_bench.sv */
// self-checking bench for the watchdog timer
`timescale 1ns/1ps
module watchdog_timer_postscaled_bench;
  import wdt_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic      clk        = 1'b0;
  logic      rst        = 1'b1;
  logic      wd_en      = 1'b1;
  wdt_sel_t  sel        = 4'h0;
  wdt_freq_t freq_sel   = 3'h3;
  logic      clock_fail = 1'b0;
  logic      clr_instr;
  logic      slp_instr;
  logic      osc_en;
  logic      timeout;
  int        errors     = 0;
  int        n_checks   = 0;

  // 20 MHz clock
  always #25 clk = ~clk;

  wdt_core_model core_u (
    .clk(clk), .watchdog_clear_instr(clr_instr), .sleep_instr(slp_instr));

  wdt_top dut_u (
    .clk(clk), .rst(rst), .watchdog_enable(wd_en), .config_word_two_high_sel(sel),
    .watchdog_clear_instr(clr_instr), .sleep_instr(slp_instr),
    .internal_osc_freq_select(freq_sel), .clock_fail(clock_fail),
    .low_freq_osc_en(osc_en), .watchdog_timeout(timeout));

  // ==========================================================
  // helpers
  task automatic check_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // timeout must stay low for n edges
  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge clk);
      check_bit(timeout, 1'b0);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  // oscillator enable follows the watchdog enable, no timeout in reset
  task automatic t_reset_osc();
    repeat (7) @(negedge clk);
    check_bit(timeout, 1'b0);
    check_bit(osc_en, 1'b1);
    wd_en = 1'b0;
    #1;
    check_bit(osc_en, 1'b0);
    @(negedge clk);
    wd_en = 1'b1;
    rst   = 1'b0;
    #1;
    check_bit(osc_en, 1'b1);
    $display("test reset_osc done");
  endtask

  // every clear source except watchdog disable zeroes the running base count, expiry 4 ms after the last one
  // the base count is looked at inside the block, it has no pin of its own
  task automatic t_event_chain();
    quiet(2000);
    check_bit(dut_u.base_cnt != '0, 1'b1);
    core_u.issue(1'b0);
    check_bit(dut_u.base_cnt == '0, 1'b1);
    quiet(2000);
    check_bit(dut_u.base_cnt != '0, 1'b1);
    clock_fail = 1'b1;
    @(negedge clk);
    clock_fail = 1'b0;
    check_bit(dut_u.base_cnt == '0, 1'b1);
    quiet(2000);
    check_bit(dut_u.base_cnt != '0, 1'b1);
    freq_sel = 3'h5;
    @(negedge clk);
    check_bit(dut_u.base_cnt == '0, 1'b1);
    quiet(2000);
    check_bit(dut_u.base_cnt != '0, 1'b1);
    core_u.issue(1'b1);
    check_bit(dut_u.base_cnt == '0, 1'b1);
    quiet(79999);
    @(negedge clk);
    check_bit(timeout, 1'b1);
    @(negedge clk);
    check_bit(timeout, 1'b0);
    $display("test event_chain done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    t_reset_osc();
    t_event_chain();
    final_report();
  end
endmodule

/* testbench/wdt_core_model.sv */
// processor core model that issues clear and sleep instructions
`timescale 1ns/1ps
module wdt_core_model (
  input  wire logic clk,                  // system clock
  output logic      watchdog_clear_instr, // clear instruction pulse
  output logic      sleep_instr           // sleep instruction pulse
);
  // ==========================================================
  // instruction issue
  // both lines idle low, instructions are never held across cycles
  initial begin
    watchdog_clear_instr = 1'b0;
    sleep_instr          = 1'b0;
  end

  // one-cycle pulse launched and released on falling edges
  task automatic issue(input logic is_sleep);
    @(negedge clk);
    if (is_sleep) begin
      sleep_instr = 1'b1;
    end else begin
      watchdog_clear_instr = 1'b1;
    end
    @(negedge clk);
    watchdog_clear_instr = 1'b0;
    sleep_instr          = 1'b0;
  endtask
endmodule
